// ---- shr_top.sv ----
// sealer auxiliary control: reset, cycle counter, hold, impulses, compensation, locks
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - external reset aborts cycle, impulses, errors
// - external reset forces output near zero
// - external reset shows active status
// - calibration continues through external reset
// - 500 ms init refuses new start
// - count start activations, not manual key
// - clear count on enter or overflow
// - hold off shows live temperature
// - hold on shows last phase-end value
// - two-second hold after each phase
// - bar always live, output live outside reset, calibration and compensation
// - hold indicator blanks 100 ms on update
// - impulse length configurable, default 1.7 ms
// - manual compensation needs enter within 2 s
// - compensation 2 s, busy, output near zero
// - automatic compensation after good calibration
// - manual key heats unless locked
// - Fahrenheit only for display, Celsius inside
// - menu held 2 s toggles lock
// - locked menu viewable, changes rejected, notice
// - lock clear at reset, stays until toggled
// - calibration suppresses heat, output near zero
module shr_top #(
  parameter int CLK_PER_US = shr_pkg::CLK_MHZ,
  parameter int US_PER_MS = 1000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_reset_pin,
  input wire logic start_pin,
  input wire logic line_contactor_pin,
  input wire logic manual_heat_key,
  input wire logic enter_key,
  input wire logic menu_key,
  input wire logic [11:0] actual_temp,
  input wire logic cal_running,
  input wire logic cal_ok,
  input wire logic heat_phase_end,
  input wire logic home_display,
  input wire logic power_up_msg,
  input wire logic counter_viewed,
  input wire logic config_menu_open,
  output logic heat_enable,
  output logic cycle_abort,
  output logic meas_pulse,
  output logic error_contactor,
  output logic ext_reset_active,
  output logic start_refused,
  output logic [11:0] actual_out,
  output logic [11:0] bar_temp,
  output logic [15:0] display_temp,
  output logic hold_indicator,
  output logic comp_prompt,
  output logic comp_busy,
  output logic config_locked,
  output logic config_change_ok,
  output logic lock_confirm,
  output logic lock_notice
);
  logic us_tick, ms_tick;
  logic [5:0] pins_s;
  logic ext_rst_s, start_s, contactor_s, key_man_s, key_ent_s, key_menu_s;
  logic ext_rst_d_reg, start_d_reg, ent_d_reg, menu_open_d_reg;
  logic [5:0] ctrl_reg;
  logic [15:0] imp_len_reg;
  logic [29:0] cycles_reg;
  logic [12:0] init_cnt_reg, cont_cnt_reg, hold_cnt_reg, blank_cnt_reg;
  logic [12:0] win_cnt_reg, comp_cnt_reg, menu_cnt_reg, conf_cnt_reg, note_cnt_reg;
  logic [15:0] imp_us_reg;
  logic held_valid_reg, menu_done_reg;
  logic [11:0] held_val_reg;
  logic [1:0] hold_mode, comp_mode;
  logic key_lock, fahr, start_ok, start_edge, ext_fall, enter_edge, hold_show;

  // decrement on the millisecond tick, stopping at zero
  function automatic logic [12:0] ms_dec(input logic [12:0] v, input logic tick);
    ms_dec = (tick && v != 13'h0000) ? v - 13'h0001 : v;
  endfunction

  // Celsius kept inside, converted only for the display
  function automatic logic [15:0] to_disp(input logic [11:0] c, input logic f);
    logic [15:0] w;
    w = {4'h0, c};
    to_disp = f ? 16'((w * 16'h0009) / 16'h0005 + 16'h0020) : w;
  endfunction

  shr_sync #(.W(6)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din({ext_reset_pin, start_pin, line_contactor_pin, manual_heat_key, enter_key, menu_key}),
    .dout(pins_s)
  );
  assign {ext_rst_s, start_s, contactor_s, key_man_s, key_ent_s, key_menu_s} = pins_s;

  // one common millisecond tick for every millisecond interval; the impulse runs on the microsecond tick
  shr_tick #(.CLK_PER_US(CLK_PER_US), .US_PER_MS(US_PER_MS)) u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .us_tick(us_tick),
    .ms_tick(ms_tick)
  );

  assign hold_mode = ctrl_reg[shr_pkg::CTRL_HOLD_LSB +: 2];
  assign comp_mode = ctrl_reg[shr_pkg::CTRL_COMP_LSB +: 2];
  assign key_lock = ctrl_reg[shr_pkg::CTRL_KEY_LOCK];
  assign fahr = ctrl_reg[shr_pkg::CTRL_FAHR];
  // start allowed outside reset, init and calibration
  assign start_ok = !ext_rst_s && init_cnt_reg == 13'h0000 && !cal_running;
  assign start_edge = start_s && !start_d_reg;
  assign ext_fall = !ext_rst_s && ext_rst_d_reg;
  assign enter_edge = key_ent_s && !ent_d_reg;

  // edge history
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ext_rst_d_reg <= 1'b0;
      start_d_reg <= 1'b0;
      ent_d_reg <= 1'b0;
      menu_open_d_reg <= 1'b0;
    end else begin
      ext_rst_d_reg <= ext_rst_s;
      start_d_reg <= start_s;
      ent_d_reg <= key_ent_s;
      menu_open_d_reg <= config_menu_open;
    end
  end

  // wishbone slave, ack one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= shr_pkg::CTRL_RESET;
      imp_len_reg <= shr_pkg::IMP_LEN_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i) begin
          if (wb_adr_i == shr_pkg::OFF_CTRL && wb_sel_i[0])
            ctrl_reg <= wb_dat_i[5:0];
          if (wb_adr_i == shr_pkg::OFF_IMP_LEN && wb_sel_i[0])
            imp_len_reg[7:0] <= wb_dat_i[7:0];
          if (wb_adr_i == shr_pkg::OFF_IMP_LEN && wb_sel_i[1])
            imp_len_reg[15:8] <= wb_dat_i[15:8];
          wb_dat_o <= 32'h00000000;
        end else begin
          case (wb_adr_i)
            shr_pkg::OFF_CTRL: wb_dat_o <= {26'h0000000, ctrl_reg};
            shr_pkg::OFF_IMP_LEN: wb_dat_o <= {16'h0000, imp_len_reg};
            shr_pkg::OFF_CYCLES: wb_dat_o <= {2'h0, cycles_reg};
            shr_pkg::OFF_STATUS: wb_dat_o <= {24'h000000, config_locked, comp_busy, comp_prompt,
              hold_indicator, error_contactor, start_refused, ext_reset_active, heat_enable};
            shr_pkg::OFF_DISPLAY: wb_dat_o <= {16'h0000, display_temp};
            default: wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // init window after release and contactor check window
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      init_cnt_reg <= 13'h0000;
      cont_cnt_reg <= 13'h0000;
      error_contactor <= 1'b0;
    end else begin
      init_cnt_reg <= ext_rst_s ? shr_pkg::INIT_MS : ms_dec(init_cnt_reg, ms_tick);
      cont_cnt_reg <= ext_fall ? shr_pkg::CONTACTOR_MS : ms_dec(cont_cnt_reg, ms_tick);
      if (ext_rst_s)
        error_contactor <= 1'b0;
      else if (cont_cnt_reg == 13'h0001 && ms_tick && !contactor_s)
        error_contactor <= 1'b1;
    end
  end

  // heating request, abort and status flags
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      heat_enable <= 1'b0;
      cycle_abort <= 1'b0;
      ext_reset_active <= 1'b0;
      start_refused <= 1'b1;
    end else begin
      // calibration itself is never aborted here, only heating
      cycle_abort <= ext_rst_s;
      ext_reset_active <= ext_rst_s;
      start_refused <= !start_ok;
      heat_enable <= !ext_rst_s && !cal_running && comp_cnt_reg == 13'h0000 &&
        ((start_s && start_ok) || (key_man_s && home_display && !key_lock));
    end
  end

  // cycle counter counts only the start input
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cycles_reg <= 30'h00000000;
    end else if (enter_edge && counter_viewed) begin
      cycles_reg <= 30'h00000000;
    end else if (start_edge && start_ok) begin
      cycles_reg <= (cycles_reg == shr_pkg::CYCLE_MAX) ? 30'h00000000 :
        cycles_reg + 30'h00000001;
    end
  end

  // measuring impulse at the start of each period
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      imp_us_reg <= 16'h0000;
      meas_pulse <= 1'b0;
    end else if (ext_rst_s) begin
      imp_us_reg <= 16'h0000;
      meas_pulse <= 1'b0;
    end else begin
      if (us_tick)
        imp_us_reg <= (imp_us_reg >= shr_pkg::IMP_PERIOD_US - 16'h0001) ? 16'h0000 :
          imp_us_reg + 16'h0001;
      meas_pulse <= imp_us_reg < imp_len_reg;
    end
  end

  // held value, two-second window and indicator blanking
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      held_valid_reg <= 1'b0;
      held_val_reg <= 12'h000;
      hold_cnt_reg <= 13'h0000;
      blank_cnt_reg <= 13'h0000;
    end else if (heat_phase_end) begin
      held_valid_reg <= 1'b1;
      held_val_reg <= actual_temp;
      hold_cnt_reg <= shr_pkg::HOLD_MS;
      blank_cnt_reg <= shr_pkg::BLANK_MS;
    end else begin
      hold_cnt_reg <= ms_dec(hold_cnt_reg, ms_tick);
      blank_cnt_reg <= ms_dec(blank_cnt_reg, ms_tick);
    end
  end

  always_comb begin
    case (hold_mode)
      shr_pkg::HOLD_ON: hold_show = held_valid_reg;
      shr_pkg::HOLD_2S: hold_show = hold_cnt_reg != 13'h0000;
      default: hold_show = 1'b0;
    endcase
  end

  // display follows hold, bar stays live, output live outside reset, calibration and compensation
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      display_temp <= 16'h0000;
      hold_indicator <= 1'b0;
      bar_temp <= 12'h000;
      actual_out <= shr_pkg::NEAR_ZERO;
    end else begin
      display_temp <= to_disp(hold_show ? held_val_reg : actual_temp, fahr);
      hold_indicator <= hold_show && blank_cnt_reg == 13'h0000;
      bar_temp <= actual_temp;
      if (ext_rst_s || cal_running || comp_cnt_reg != 13'h0000)
        actual_out <= shr_pkg::NEAR_ZERO;
      else
        actual_out <= actual_temp;
    end
  end

  // phase compensation after a good calibration
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      win_cnt_reg <= 13'h0000;
      comp_cnt_reg <= 13'h0000;
      comp_prompt <= 1'b0;
      comp_busy <= 1'b0;
    end else begin
      if (cal_ok && comp_mode == shr_pkg::COMP_AUTO) begin
        comp_cnt_reg <= shr_pkg::COMP_RUN_MS;
        win_cnt_reg <= 13'h0000;
      end else if (cal_ok && comp_mode == shr_pkg::COMP_MANUAL) begin
        win_cnt_reg <= shr_pkg::COMP_WIN_MS;
      end else if (enter_edge && win_cnt_reg != 13'h0000) begin
        comp_cnt_reg <= shr_pkg::COMP_RUN_MS;
        win_cnt_reg <= 13'h0000;
      end else begin
        win_cnt_reg <= ms_dec(win_cnt_reg, ms_tick);
        comp_cnt_reg <= ms_dec(comp_cnt_reg, ms_tick);
      end
      comp_prompt <= win_cnt_reg != 13'h0000;
      comp_busy <= comp_cnt_reg != 13'h0000;
    end
  end

  // configuration lock toggled by a long menu press at power-up
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      config_locked <= 1'b0;
      menu_cnt_reg <= 13'h0000;
      menu_done_reg <= 1'b0;
      conf_cnt_reg <= 13'h0000;
      note_cnt_reg <= 13'h0000;
    end else begin
      conf_cnt_reg <= ms_dec(conf_cnt_reg, ms_tick); // confirm runs down held or not
      if (!(key_menu_s && power_up_msg)) begin
        menu_cnt_reg <= 13'h0000;
        menu_done_reg <= 1'b0;
      end else if (ms_tick && !menu_done_reg) begin
        if (menu_cnt_reg == shr_pkg::MENU_HOLD_MS - 13'h0001) begin
          config_locked <= !config_locked;
          menu_done_reg <= 1'b1;
          conf_cnt_reg <= shr_pkg::CONFIRM_MS;
        end else begin
          menu_cnt_reg <= menu_cnt_reg + 13'h0001;
        end
      end
      if (config_menu_open && !menu_open_d_reg && config_locked)
        note_cnt_reg <= shr_pkg::NOTICE_MS;
      else
        note_cnt_reg <= ms_dec(note_cnt_reg, ms_tick);
    end
  end

  // lock outputs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      config_change_ok <= 1'b1;
      lock_confirm <= 1'b0;
      lock_notice <= 1'b0;
    end else begin
      config_change_ok <= !config_locked;
      lock_confirm <= conf_cnt_reg != 13'h0000;
      lock_notice <= note_cnt_reg != 13'h0000;
    end
  end

  AST_RST_OUT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ext_rst_s |=> actual_out == shr_pkg::NEAR_ZERO) else $error("output not near zero in reset");
  AST_RST_STATUS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ext_rst_s |=> ext_reset_active && cycle_abort) else $error("reset status missing");
  AST_NO_IMPULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ext_rst_s ##1 ext_rst_s |=> !meas_pulse) else $error("impulse during reset");
  AST_INIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ext_fall |=> start_refused [*3]) else $error("start allowed during init");
  AST_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    start_edge && start_ok && !(enter_edge && counter_viewed) && cycles_reg != shr_pkg::CYCLE_MAX
    |=> cycles_reg == $past(cycles_reg) + 30'h00000001) else $error("cycle not counted");
  AST_HOLD_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hold_mode == shr_pkg::HOLD_OFF && !fahr |=> display_temp == {4'h0, $past(actual_temp)})
    else $error("display not live with hold off");
  AST_BAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> bar_temp == $past(actual_temp)) else $error("bar not live");
  AST_KEY_LOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    key_lock && !start_s |=> !heat_enable) else $error("locked manual key heated");
  AST_CAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cal_running |=> !heat_enable && actual_out == shr_pkg::NEAR_ZERO)
    else $error("heat or output during calibration");
  AST_COMP_AUTO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cal_ok && comp_mode == shr_pkg::COMP_AUTO |=> ##1 comp_busy) else $error("no auto compensation");
  AST_CONFIRM: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ms_tick && conf_cnt_reg != 13'h0000 && !key_menu_s |=> conf_cnt_reg < $past(conf_cnt_reg))
    else $error("lock confirmation not running down");
endmodule
`default_nettype wire

// ---- shr_pkg.sv ----
// constants shared by the sealer auxiliary control block
package shr_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IMP_LEN = 8'h04;
  localparam logic [7:0] OFF_CYCLES = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_DISPLAY = 8'h10;
  // control field positions
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_COMP_LSB = 2;
  localparam int CTRL_KEY_LOCK = 4;
  localparam int CTRL_FAHR = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // hold and compensation modes
  localparam logic [1:0] HOLD_OFF = 2'h0;
  localparam logic [1:0] HOLD_ON = 2'h1;
  localparam logic [1:0] HOLD_2S = 2'h2;
  localparam logic [1:0] COMP_OFF = 2'h0;
  localparam logic [1:0] COMP_MANUAL = 2'h1;
  localparam logic [1:0] COMP_AUTO = 2'h2;
  // measuring impulse length and period in microseconds
  localparam logic [15:0] IMP_LEN_RESET = 16'h06a4;
  localparam logic [15:0] IMP_PERIOD_US = 16'h2710;
  // intervals in milliseconds
  localparam logic [12:0] INIT_MS = 13'h01f4;
  localparam logic [12:0] CONTACTOR_MS = 13'h0032;
  localparam logic [12:0] HOLD_MS = 13'h07d0;
  localparam logic [12:0] BLANK_MS = 13'h0064;
  localparam logic [12:0] COMP_WIN_MS = 13'h07d0;
  localparam logic [12:0] COMP_RUN_MS = 13'h07d0;
  localparam logic [12:0] MENU_HOLD_MS = 13'h07d0;
  localparam logic [12:0] CONFIRM_MS = 13'h0bb8;
  localparam logic [12:0] NOTICE_MS = 13'h1388;
  // counter limit and near-zero output code
  localparam logic [29:0] CYCLE_MAX = 30'h3b9ac9ff;
  localparam logic [11:0] NEAR_ZERO = 12'h000;
  // clock rate
  localparam int CLK_MHZ = 250;
endpackage

// ---- shr_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module shr_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- shr_tick.sv ----
// microsecond and millisecond enable pulses from the system clock
`timescale 1ns/1ps
`default_nettype none
module shr_tick #(
  parameter int CLK_PER_US = 250,
  parameter int US_PER_MS = 1000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic us_tick,
  output logic ms_tick
);
  logic [11:0] clk_cnt_reg;
  logic [11:0] us_cnt_reg;
  initial begin
    if (CLK_PER_US < 1 || CLK_PER_US > 4096 || US_PER_MS < 1 || US_PER_MS > 4096)
      $error("shr_tick: divider out of range");
  end
  // cascaded dividers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clk_cnt_reg <= 12'h000;
      us_cnt_reg <= 12'h000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      if (clk_cnt_reg == 12'(CLK_PER_US - 1)) begin
        clk_cnt_reg <= 12'h000;
        us_tick <= 1'b1;
        if (us_cnt_reg == 12'(US_PER_MS - 1)) begin
          us_cnt_reg <= 12'h000;
          ms_tick <= 1'b1;
        end else begin
          us_cnt_reg <= us_cnt_reg + 12'h001;
        end
      end else begin
        clk_cnt_reg <= clk_cnt_reg + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- shr_host.sv ----
// machine controller model driving the external reset and line contactor pins
`timescale 1ns/1ps
`default_nettype none
module shr_host #(
  parameter int MS_CLK = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hold_reset,
  input wire logic late,
  output logic ext_reset_pin,
  output logic line_contactor_pin
);
  int cnt;
  // reset drops the contactor; it is energised again 10 ms after release, or 80 ms when late
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ext_reset_pin <= 1'b0;
      line_contactor_pin <= 1'b1;
      cnt <= 0;
    end else if (hold_reset) begin
      ext_reset_pin <= 1'b1;
      line_contactor_pin <= 1'b0;
      cnt <= 0;
    end else begin
      ext_reset_pin <= 1'b0;
      if (cnt < (late ? 80 : 10) * MS_CLK) begin
        cnt <= cnt + 1;
      end else begin
        line_contactor_pin <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the sealer auxiliary control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed, base;
  logic ext_reset_pin, start_pin, line_contactor_pin, manual_heat_key, enter_key, menu_key;
  logic [11:0] actual_temp, actual_out, bar_temp, ta, tb_, tc;
  logic cal_running, cal_ok, heat_phase_end, home_display, power_up_msg, counter_viewed;
  logic config_menu_open, heat_enable, cycle_abort, meas_pulse, error_contactor;
  logic ext_reset_active, start_refused, hold_indicator, comp_prompt, comp_busy;
  logic config_locked, config_change_ok, lock_confirm, lock_notice, hold_reset, late;
  logic [15:0] display_temp, imp;
  int error_cnt, check_count, cyc_n, run, last_w, n;
  shr_top #(.CLK_PER_US(2), .US_PER_MS(4)) DUT (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_reset_pin,
    .start_pin, .line_contactor_pin, .manual_heat_key, .enter_key, .menu_key, .actual_temp,
    .cal_running, .cal_ok, .heat_phase_end, .home_display, .power_up_msg, .counter_viewed,
    .config_menu_open, .heat_enable, .cycle_abort, .meas_pulse, .error_contactor,
    .ext_reset_active, .start_refused, .actual_out, .bar_temp, .display_temp, .hold_indicator,
    .comp_prompt, .comp_busy, .config_locked, .config_change_ok, .lock_confirm, .lock_notice);
  shr_host #(.MS_CLK(8)) host (.clk_sys, .reset_n, .hold_reset, .late, .ext_reset_pin,
    .line_contactor_pin);
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // impulse width and hang limit
  always @(posedge clk_sys) begin
    cyc_n++;
    if (meas_pulse === 1'b1) run++;
    else begin
      if (run != 0) last_w = run;
      run = 0;
    end
    if (cyc_n == 100000) begin
      error_cnt++;
      end_sim();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] ctrl(logic [1:0] h, logic [1:0] c, logic l, logic f);
    return {26'h0, f, l, c, h};
  endfunction
  function logic [15:0] fahr(logic [11:0] c);
    return 16'((32'(c) * 32'h9) / 32'h5 + 32'h20);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single wishbone cycle, waits on ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task ms(input int k);
    repeat (k * 8) @(posedge clk_sys);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // external reset cycle; partner energises contactor 10 ms after release, 80 ms when late
  task ext_rst(input logic lt);
    late <= lt;
    hold_reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(actual_out, 32'h0);
    chk(ext_reset_active, 1'b1);
    chk({cycle_abort, meas_pulse, error_contactor}, 3'b100);
    hold_reset <= 1'b0;
    ms(2);
    start_pin <= 1'b1;
    ms(1);
    start_pin <= 1'b0;
    ms(440);
    chk(start_refused, 1'b1);
    ms(80);
    chk({start_refused, error_contactor}, {1'b0, lt});
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, start_pin, manual_heat_key, enter_key, menu_key} = '0;
    {cal_running, cal_ok, heat_phase_end, home_display, power_up_msg} = '0;
    {counter_viewed, config_menu_open, hold_reset, late} = '0;
    {wb_adr_i, wb_dat_i, error_cnt, check_count, cyc_n, run, last_w} = '0;
    wb_sel_i = 4'hf;
    seed = 32'h48;
    actual_temp = 12'h123;
    reset_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wb(1'b0, shr_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'(shr_pkg::CTRL_RESET));
    wb(1'b0, shr_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h80, 32'h0);
    wb(1'b0, shr_pkg::OFF_IMP_LEN, 32'h0);
    chk(rd, 32'(shr_pkg::IMP_LEN_RESET));
    imp = 16'(rnd() % 64 + 10);
    wb(1'b1, shr_pkg::OFF_IMP_LEN, {16'h0, imp});
    wb(1'b1, 8'h14, 32'hffff_ffff);
    chk(wb_dat_o, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, shr_pkg::OFF_IMP_LEN, 32'h0);
    chk(rd, {16'h0, imp});
    done("registers");
    // start pulses counted, manual key presses not
    wb(1'b0, shr_pkg::OFF_CYCLES, 32'h0);
    base = rd;
    n = int'(rnd() % 4) + 2;
    repeat (n) begin
      start_pin <= 1'b1;
      manual_heat_key <= 1'b1;
      repeat (6) @(posedge clk_sys);
      start_pin <= 1'b0;
      manual_heat_key <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
    wb(1'b0, shr_pkg::OFF_CYCLES, 32'h0);
    chk(rd, base + 32'(n));
    done("counter");
    ext_rst(1'b0);
    wb(1'b0, shr_pkg::OFF_CYCLES, 32'h0);
    chk(rd, base + 32'(n));
    ext_rst(1'b1);
    ext_rst(1'b0);
    counter_viewed <= 1'b1;
    enter_key <= 1'b1;
    repeat (6) @(posedge clk_sys);
    {counter_viewed, enter_key} <= 2'b00;
    wb(1'b0, shr_pkg::OFF_CYCLES, 32'h0);
    chk(rd, 32'h0);
    done("external reset");
    // hold modes
    ta = 12'(rnd());
    tb_ = 12'(rnd());
    tc = 12'(rnd());
    actual_temp <= ta;
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_ON, shr_pkg::COMP_OFF, 1'b0, 1'b0));
    repeat (4) @(posedge clk_sys);
    chk(display_temp, {4'h0, ta});
    heat_phase_end <= 1'b1;
    @(posedge clk_sys);
    heat_phase_end <= 1'b0;
    actual_temp <= tb_;
    repeat (4) @(posedge clk_sys);
    chk(display_temp, {4'h0, ta});
    chk({bar_temp, actual_out}, {tb_, tb_});
    chk(hold_indicator, 1'b0);
    ms(110);
    chk(hold_indicator, 1'b1);
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_OFF, shr_pkg::COMP_OFF, 1'b0, 1'b0));
    repeat (4) @(posedge clk_sys);
    chk(display_temp, {4'h0, tb_});
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_2S, shr_pkg::COMP_OFF, 1'b0, 1'b0));
    heat_phase_end <= 1'b1;
    @(posedge clk_sys);
    heat_phase_end <= 1'b0;
    actual_temp <= tc;
    ms(1900);
    chk(display_temp, {4'h0, tb_});
    ms(200);
    chk(display_temp, {4'h0, tc});
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_OFF, shr_pkg::COMP_OFF, 1'b0, 1'b1));
    repeat (4) @(posedge clk_sys);
    chk({display_temp, bar_temp}, {fahr(tc), tc});
    wb(1'b0, shr_pkg::OFF_DISPLAY, 32'h0);
    chk(rd, {16'h0, fahr(tc)});
    done("hold");
    // manual key, calibration, compensation
    home_display <= 1'b1;
    manual_heat_key <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(heat_enable, 1'b1);
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_OFF, shr_pkg::COMP_MANUAL, 1'b1, 1'b0));
    repeat (8) @(posedge clk_sys);
    chk(heat_enable, 1'b0);
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_OFF, shr_pkg::COMP_MANUAL, 1'b0, 1'b0));
    cal_running <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({heat_enable, actual_out}, 13'h0);
    {cal_running, manual_heat_key, cal_ok} <= 3'b001;
    @(posedge clk_sys);
    cal_ok <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(comp_prompt, 1'b1);
    enter_key <= 1'b1;
    repeat (8) @(posedge clk_sys);
    enter_key <= 1'b0;
    chk({comp_busy, actual_out}, 13'h1000);
    ms(1900);
    chk(comp_busy, 1'b1);
    ms(200);
    chk(comp_busy, 1'b0);
    cal_ok <= 1'b1;
    @(posedge clk_sys);
    cal_ok <= 1'b0;
    ms(2100);
    chk(comp_prompt, 1'b0);
    enter_key <= 1'b1;
    repeat (8) @(posedge clk_sys);
    enter_key <= 1'b0;
    chk(comp_busy, 1'b0);
    wb(1'b1, shr_pkg::OFF_CTRL, ctrl(shr_pkg::HOLD_OFF, shr_pkg::COMP_AUTO, 1'b0, 1'b0));
    cal_ok <= 1'b1;
    @(posedge clk_sys);
    cal_ok <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(comp_busy, 1'b1);
    done("compensation");
    // configuration lock toggle and notice
    {power_up_msg, menu_key} <= 2'b11;
    ms(1900);
    chk(config_locked, 1'b0);
    ms(200);
    chk({config_locked, lock_confirm}, 2'b11);
    {power_up_msg, menu_key, config_menu_open} <= 3'b001;
    repeat (8) @(posedge clk_sys);
    chk({lock_notice, config_change_ok}, 2'b10);
    {power_up_msg, menu_key, config_menu_open} <= 3'b110;
    ms(2100);
    chk(config_locked, 1'b0);
    menu_key <= 1'b0;
    chk(32'(last_w), 32'(imp) * 32'h2);
    done("lock");
    end_sim();
  end
endmodule
`default_nettype wire
